/* rtl/ckr_consts.vh */
// constants of the carkit control register group: addresses, fields, timing
// assumes a 6-bit immediate register address and an 8 ns link clock
// What this block does
// R01: control register: write at 19h, set at 1Ah, clear at 1Bh, all read back
// R02: link sets both route enables before selecting carkit mode elsewhere
// R03: with receive route off, link data line 1 is held high
// R04: bit 1 drives the ID pin to ground; bit 0 always reads 0
// R05: bit 2 routes link data line 0 onto DM
// R06: bit 3 routes DP onto link data line 1
// R07: enable register: write at 1Dh, set at 1Eh, clear at 1Fh, all read back
// R08: enable bit 0 raises alt_int when ID becomes floating
// R09: enable bit 1 raises alt_int when ID stops floating
// R10: link should enable the ID pull-up when using floating detection
// R11: unimplemented carkit and DP bits and reserved bits read zero
// R12: enable bit 5, ORed with vendor bit 6, raises alt_int on conversion done
// R13: status at 20h, bit 0 shows ID floating while pull-up is on
// R14: status bits 5:3 give the ID resistor code
// R15: status bit 6 sets when the 282 us measurement finishes
// R16: done clears on a vendor register read, not on a status read
// R17: latch register at 21h clears its auto-clear bits when read
// R18: latch bit 0 holds an enabled ID floating edge until read
// R19: latch bit 3 holds an enabled done rising edge until read
// R20: writing or setting the start bit measures; it clears on completion
// R21: set ORs bits in, clear removes ones written; read-only bits ignore writes
// R22: every carkit bit resets to 0
`ifndef CKR_CONSTS_VH
`define CKR_CONSTS_VH

`define CKR_ADDR_CTRL      6'h19
`define CKR_ADDR_IRQ_EN    6'h1D
`define CKR_ADDR_STATUS    6'h20
`define CKR_ADDR_LATCH     6'h21
`define CKR_ADDR_VENDOR    6'h36

`define CKR_KIND_WRITE     2'h0
`define CKR_KIND_SET       2'h1
`define CKR_KIND_CLEAR     2'h2
`define CKR_KIND_NONE      2'h3

`define CKR_CTRL_MASK      8'h0E
`define CKR_IRQ_EN_MASK    8'h23
`define CKR_VENDOR_MASK    8'h70
`define CKR_RESET_BYTE     8'h00
`define CKR_VENDOR_STORE   8'h60

`define CKR_BIT_ID_GND     1
`define CKR_BIT_TX_EN      2
`define CKR_BIT_RX_EN      3
`define CKR_BIT_FLOAT_RISE 0
`define CKR_BIT_FLOAT_FALL 1
`define CKR_BIT_RID_INT    5
`define CKR_BIT_V_START    4
`define CKR_BIT_V_RID_INT  6

`define CKR_RID_TIME_NS    282000
`define CKR_CLK_PERIOD_NS  8

`endif

/* rtl/ckr_rid_timer.v */
// sequencer of the ID resistor measurement: timing and capture of the code
// assumes the analogue converter settles its code within the measurement time
`timescale 1ns/1ps

module ckr_rid_timer #(
	parameter [15:0] CYCLES = 16'h89B2
) (
	input  wire       clk,
	input  wire       reset,
	input  wire       start,
	input  wire [2:0] code_in,
	output reg        busy,
	output reg        done_pulse,
	output reg  [2:0] code,
	output reg        meas_enable
);

	reg [15:0] count;

	// count out the measurement, then capture the code and pulse done
	always @(posedge clk) begin
		if (reset) begin
			busy        <= 1'b0;
			done_pulse  <= 1'b0;
			code        <= 3'h0;
			meas_enable <= 1'b0;
			count       <= 16'h0000;
		end else begin
			done_pulse <= 1'b0;
			if (!busy) begin
				if (start) begin // R20
					busy        <= 1'b1;
					meas_enable <= 1'b1;
					count       <= CYCLES - 16'h0001;
				end
			end else if (count == 16'h0000) begin
				busy        <= 1'b0; // R20
				meas_enable <= 1'b0;
				done_pulse  <= 1'b1; // R15
				code        <= code_in; // R14
			end else begin
				count <= count - 16'h0001;
			end
		end
	end

endmodule // ckr_rid_timer

/* rtl/ckr_carkit_regs.v */
// carkit control, interrupt enable, status and latch registers, with the
// vendor resistor conversion register that shares their done and enable bits
// assumes a register port on the link clock, one access per cycle, and
// analogue ID float and resistor code signals arriving from outside the clock
`include "ckr_consts.vh"
`timescale 1ns/1ps

module ckr_carkit_regs #(
	parameter RID_TIME_NS = `CKR_RID_TIME_NS
) (
	input  wire       clk,
	input  wire       reset,
	input  wire [5:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata,
	output reg        reg_rvalid,
	input  wire       id_pullup_enable,
	input  wire       id_float_pin,
	input  wire [2:0] rid_adc_code,
	input  wire       link_data0_in,
	output reg        link_data1_out,
	output reg        dm_out,
	output reg        dm_oe,
	input  wire       dp_pin,
	output reg        id_out,
	output reg        id_oe,
	output reg        rid_meas_enable,
	output reg        alt_int
);

	// measurement length in link clock cycles
	localparam integer RID_CYCLES_I = RID_TIME_NS / `CKR_CLK_PERIOD_NS;
	localparam [15:0]  RID_CYCLES   = RID_CYCLES_I[15:0];

	// software visible state
	reg [7:0] line_ctrl;
	reg [7:0] irq_en;
	reg [7:0] vendor_bits;
	reg       conv_done;
	reg       latch_float;
	reg       latch_rid;

	// pin synchronisers and filtered levels
	reg       float_s1;
	reg       float_s2;
	reg       float_s3;
	reg       float_state;
	reg       dp_s1;
	reg       dp_s2;
	reg       dp_s3;
	reg       dp_state;

	// converter handshake
	wire       rid_busy;
	wire       rid_done_pulse;
	wire [2:0] rid_code;
	wire       rid_meas_en_w;

	// write decode and next values
	reg  [1:0] kind_ctrl;
	reg  [1:0] kind_en;
	reg  [1:0] kind_vendor;
	reg  [7:0] next_line_ctrl;
	reg  [7:0] next_irq_en;
	reg  [7:0] next_vendor;
	reg        start_req;
	reg        float_qual;
	reg        float_rise;
	reg        float_fall;
	reg        ev_float;
	reg        ev_rid;
	reg        rid_int_eff;
	reg        rd_latch;
	reg        rd_vendor;
	reg  [7:0] status_byte;
	reg  [7:0] vendor_byte;
	reg  [7:0] next_rdata;

	// which of write, set or clear an address means for a register base
	function [1:0] ckr_kind;
		input [5:0] addr;
		input [5:0] base;
		reg   [5:0] diff;
		begin
			diff = addr - base;
			if (diff == 6'h00)
				ckr_kind = `CKR_KIND_WRITE;
			else if (diff == 6'h01)
				ckr_kind = `CKR_KIND_SET;
			else if (diff == 6'h02)
				ckr_kind = `CKR_KIND_CLEAR;
			else
				ckr_kind = `CKR_KIND_NONE;
		end
	endfunction

	// apply a write, set or clear to the writable bits only
	function [7:0] ckr_apply;
		input [7:0] cur;
		input [7:0] wdata;
		input [1:0] kind;
		input [7:0] mask;
		reg   [7:0] bits;
		begin
			bits = wdata & mask;
			case (kind)
			`CKR_KIND_WRITE: ckr_apply = bits | (cur & ~mask);
			`CKR_KIND_SET:   ckr_apply = cur | bits;
			`CKR_KIND_CLEAR: ckr_apply = cur & ~bits;
			default:         ckr_apply = cur;
			endcase
		end
	endfunction

	// resistor measurement sequencer
	ckr_rid_timer #(
		.CYCLES      (RID_CYCLES)
	) u_rid_timer (
		.clk         (clk),
		.reset       (reset),
		.start       (start_req),
		.code_in     (rid_adc_code),
		.busy        (rid_busy),
		.done_pulse  (rid_done_pulse),
		.code        (rid_code),
		.meas_enable (rid_meas_en_w)
	);

	// address decode of write, set and clear for each writable register
	always @* begin
		kind_ctrl   = reg_wr ? ckr_kind(reg_addr, `CKR_ADDR_CTRL)
		                     : `CKR_KIND_NONE; // R01
		kind_en     = reg_wr ? ckr_kind(reg_addr, `CKR_ADDR_IRQ_EN)
		                     : `CKR_KIND_NONE; // R07
		kind_vendor = reg_wr ? ckr_kind(reg_addr, `CKR_ADDR_VENDOR)
		                     : `CKR_KIND_NONE;
	end

	// next register contents; masks keep read-only bits at zero
	always @* begin
		next_line_ctrl = ckr_apply(line_ctrl, reg_wdata, kind_ctrl,
		                           `CKR_CTRL_MASK); // R21 R04 R11
		next_irq_en    = ckr_apply(irq_en, reg_wdata, kind_en,
		                           `CKR_IRQ_EN_MASK); // R21 R11
		next_vendor    = ckr_apply(vendor_bits, reg_wdata, kind_vendor,
		                           `CKR_VENDOR_MASK); // R21
	end

	// a one written or set into the start bit launches a measurement;
	// a start while the sequencer is busy is dropped
	always @* begin
		start_req = (kind_vendor != `CKR_KIND_NONE) &&
		            (kind_vendor != `CKR_KIND_CLEAR) &&
		            next_vendor[`CKR_BIT_V_START] && !rid_busy; // R20
	end

	// ID floating edges, seen only once two synchroniser stages agree
	always @* begin
		if (float_s2 == float_s3)
			float_qual = float_s3 & id_pullup_enable; // R13
		else
			float_qual = float_state;
		float_rise = float_qual & ~float_state;
		float_fall = ~float_qual & float_state;
		ev_float   = (float_rise & irq_en[`CKR_BIT_FLOAT_RISE]) |
		             (float_fall & irq_en[`CKR_BIT_FLOAT_FALL]); // R08 R09
	end

	// conversion done event, enabled from either register
	always @* begin
		rid_int_eff = irq_en[`CKR_BIT_RID_INT] |
		              vendor_bits[`CKR_BIT_V_RID_INT]; // R12
		ev_rid      = rid_done_pulse & ~conv_done & rid_int_eff; // R19
	end

	// reads that have side effects
	always @* begin
		rd_latch  = reg_rd && (reg_addr == `CKR_ADDR_LATCH); // R17
		rd_vendor = reg_rd &&
		            (ckr_kind(reg_addr, `CKR_ADDR_VENDOR) !=
		             `CKR_KIND_NONE); // R16
	end

	// read data mux; unmapped addresses read zero
	always @* begin
		status_byte = {1'b0, conv_done, rid_code, 2'b00,
		               float_state}; // R13 R14 R15 R11
		vendor_byte = {1'b0, vendor_bits[6:5], rid_busy, conv_done,
		               rid_code}; // R20
		next_rdata  = 8'h00;
		if (ckr_kind(reg_addr, `CKR_ADDR_CTRL) != `CKR_KIND_NONE)
			next_rdata = line_ctrl; // R01
		else if (ckr_kind(reg_addr, `CKR_ADDR_IRQ_EN) != `CKR_KIND_NONE)
			next_rdata = irq_en; // R07
		else if (reg_addr == `CKR_ADDR_STATUS)
			next_rdata = status_byte;
		else if (reg_addr == `CKR_ADDR_LATCH)
			next_rdata = {4'h0, latch_rid, 2'b00, latch_float}; // R11
		else if (ckr_kind(reg_addr, `CKR_ADDR_VENDOR) != `CKR_KIND_NONE)
			next_rdata = vendor_byte;
	end

	// ID float synchroniser: three stages, a level counts when 2 and 3 agree
	always @(posedge clk) begin
		if (reset) begin
			float_s1 <= 1'b0;
			float_s2 <= 1'b0;
			float_s3 <= 1'b0;
		end else begin
			float_s1 <= id_float_pin;
			float_s2 <= float_s1;
			float_s3 <= float_s2;
		end
	end

	// DP synchroniser, same scheme, filtered level kept in dp_state
	always @(posedge clk) begin
		if (reset) begin
			dp_s1    <= 1'b0;
			dp_s2    <= 1'b0;
			dp_s3    <= 1'b0;
			dp_state <= 1'b0;
		end else begin
			dp_s1    <= dp_pin;
			dp_s2    <= dp_s1;
			dp_s3    <= dp_s2;
			if (dp_s2 == dp_s3)
				dp_state <= dp_s3;
		end
	end

	// writable registers
	always @(posedge clk) begin
		if (reset) begin
			line_ctrl   <= `CKR_RESET_BYTE; // R22
			irq_en      <= `CKR_RESET_BYTE; // R22
			vendor_bits <= `CKR_RESET_BYTE; // R22
		end else begin
			line_ctrl   <= next_line_ctrl;
			irq_en      <= next_irq_en;
			// the start bit is shown from the sequencer, not stored
			vendor_bits <= next_vendor & `CKR_VENDOR_STORE;
		end
	end

	// filtered ID floating level seen by status and edge logic
	always @(posedge clk) begin
		if (reset)
			float_state <= 1'b0;
		else
			float_state <= float_qual; // R13
	end

	// conversion done: set by the sequencer, cleared by a vendor read
	always @(posedge clk) begin
		if (reset)
			conv_done <= 1'b0; // R22
		else if (rid_done_pulse)
			conv_done <= 1'b1; // R15
		else if (rd_vendor)
			conv_done <= 1'b0; // R16
	end

	// ID floating latch: a new edge wins over the clearing read
	always @(posedge clk) begin
		if (reset)
			latch_float <= 1'b0;
		else if (ev_float)
			latch_float <= 1'b1; // R18
		else if (rd_latch)
			latch_float <= 1'b0; // R17
	end

	// conversion latch: a new done edge wins over the clearing read
	always @(posedge clk) begin
		if (reset)
			latch_rid <= 1'b0;
		else if (ev_rid)
			latch_rid <= 1'b1; // R19
		else if (rd_latch)
			latch_rid <= 1'b0; // R17
	end

	// alternate interrupt indication for the receive command byte
	always @(posedge clk) begin
		if (reset)
			alt_int <= 1'b0;
		else
			alt_int <= ev_float | ev_rid; // R08 R09 R12
	end

	// register port answer, one cycle after the read strobe
	always @(posedge clk) begin
		if (reset) begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd)
				reg_rdata <= next_rdata;
		end
	end

	// transmit route: link data line 0 onto DM while enabled
	always @(posedge clk) begin
		if (reset) begin
			dm_out <= 1'b0;
			dm_oe  <= 1'b0;
		end else begin
			dm_oe  <= line_ctrl[`CKR_BIT_TX_EN]; // R05
			dm_out <= link_data0_in & line_ctrl[`CKR_BIT_TX_EN]; // R05
		end
	end

	// receive route: filtered DP onto link data line 1, else held high
	always @(posedge clk) begin
		if (reset)
			link_data1_out <= 1'b1; // R03
		else if (line_ctrl[`CKR_BIT_RX_EN])
			link_data1_out <= dp_state; // R06
		else
			link_data1_out <= 1'b1; // R03
	end

	// ID ground drive is an open-drain pull to ground
	always @(posedge clk) begin
		if (reset) begin
			id_out <= 1'b0;
			id_oe  <= 1'b0;
		end else begin
			id_out <= 1'b0;
			id_oe  <= line_ctrl[`CKR_BIT_ID_GND]; // R04
		end
	end

	// converter enable follows the sequencer by one cycle
	always @(posedge clk) begin
		if (reset)
			rid_meas_enable <= 1'b0;
		else
			rid_meas_enable <= rid_meas_en_w; // R20
	end

endmodule // ckr_carkit_regs

/* tb/ckr_link_model.sv */
// link side model: drives the register port one access at a time
// assumes the block answers a read with a valid pulse one cycle later
`timescale 1ns/1ps
module ckr_link_model (
	input  wire       clk,
	output reg  [5:0] reg_addr,
	output reg  [7:0] reg_wdata,
	output reg        reg_wr,
	output reg        reg_rd,
	input  wire [7:0] reg_rdata,
	input  wire       reg_rvalid
);
	// idle port at time zero
	initial begin
		reg_addr = 6'h3F;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// one-cycle write, then the data lines show a fresh pattern
	task wr(input [5:0] a, input [7:0] d);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge clk);
			reg_wr <= 1'b0;
			reg_wdata <= ~d;
		end
	endtask
	// one-cycle read; data taken with the valid pulse
	task rd(input [5:0] a, output [7:0] q);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge clk);
			reg_rd <= 1'b0;
			@(posedge clk);
			q = reg_rvalid ? reg_rdata : 8'hXX;
		end
	endtask
endmodule // ckr_link_model

/* tb/ckr_carkit_regs_monitor.sv */
// port assertions of the carkit register group
// assumes one clock domain and a synchronous active high reset
`timescale 1ns/1ps
module ckr_carkit_regs_monitor (
	input wire       clk,
	input wire       reset,
	input wire [5:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_wr,
	input wire       reg_rd,
	input wire [7:0] reg_rdata,
	input wire       reg_rvalid,
	input wire       link_data0_in,
	input wire       link_data1_out,
	input wire       dm_out,
	input wire       dm_oe,
	input wire       id_out,
	input wire       id_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// read answered exactly one cycle later, never unasked
	AST_RVALID: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered");
	AST_NO_RVALID: assert property (!reg_rd |=> !reg_rvalid)
		else $error("valid without read");
	// fixed zero bits of the control, status and latch bytes
	AST_CTRL_ZERO: assert property (reg_rd && reg_addr >= 6'h19 &&
		reg_addr <= 6'h1B |=> !reg_rdata[0] && reg_rdata[7:4] == 4'h0)
		else $error("control zero bits set");
	AST_STATUS_ZERO: assert property (reg_rd && reg_addr == 6'h20
		|=> !reg_rdata[7] && reg_rdata[2:1] == 2'h0)
		else $error("status zero bits set");
	AST_LATCH_ZERO: assert property (reg_rd && reg_addr == 6'h21
		|=> reg_rdata[7:4] == 4'h0 && reg_rdata[2:1] == 2'h0)
		else $error("latch zero bits set");
	// transmit route follows set and clear of bit 2
	AST_TX_ON: assert property ((reg_wr && reg_addr == 6'h1A &&
		reg_wdata[2]) ##1 !reg_wr |=> dm_oe)
		else $error("tx route not enabled");
	AST_TX_OFF: assert property ((reg_wr && reg_addr == 6'h1B &&
		reg_wdata[2]) ##1 !reg_wr |=> !dm_oe)
		else $error("tx route not disabled");
	AST_DM_DATA: assert property (dm_oe |-> dm_out == $past(link_data0_in))
		else $error("dm not following tx data");
	AST_RX_HOLD: assert property ((reg_wr && reg_addr == 6'h1B &&
		reg_wdata[3]) ##1 !reg_wr |=> link_data1_out)
		else $error("data line 1 not held high");
	AST_ID_LOW: assert property (id_oe |-> !id_out)
		else $error("id driven high");
	cover property (id_oe);
	cover property (dm_oe ##1 !dm_oe);
	cover property (reg_rd && reg_addr == 6'h21);
endmodule // ckr_carkit_regs_monitor
bind ckr_carkit_regs ckr_carkit_regs_monitor mon (.clk(clk), .reset(reset),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.link_data0_in(link_data0_in), .link_data1_out(link_data1_out),
	.dm_out(dm_out), .dm_oe(dm_oe), .id_out(id_out), .id_oe(id_oe));

/* tb/ckr_carkit_regs_test.sv */
// self-checking bench of the carkit register group
// assumes the link model owns the register port; pins are driven here
`timescale 1ns/1ps
module ckr_carkit_regs_test;
	reg        clk, reset, id_pullup_enable, id_float_pin;
	reg        link_data0_in, dp_pin;
	reg  [2:0] rid_adc_code;
	reg  [7:0] rd_val;
	wire [5:0] reg_addr;
	wire [7:0] reg_wdata, reg_rdata;
	wire       reg_wr, reg_rd, reg_rvalid, link_data1_out, dm_out, dm_oe;
	wire       id_out, id_oe, rid_meas_enable, alt_int;
	integer    n_fail = 0;
	integer    total_checks = 0;
	integer    cycles = 0;
	ckr_link_model link (.clk(clk), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
	ckr_carkit_regs #(.RID_TIME_NS(800)) dut (.clk(clk), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.id_pullup_enable(id_pullup_enable), .id_float_pin(id_float_pin),
		.rid_adc_code(rid_adc_code), .link_data0_in(link_data0_in),
		.link_data1_out(link_data1_out), .dm_out(dm_out), .dm_oe(dm_oe),
		.dp_pin(dp_pin), .id_out(id_out), .id_oe(id_oe),
		.rid_meas_enable(rid_meas_enable), .alt_int(alt_int));
	// compare and count
	task chk(input [8*8:1] what, input [7:0] exp, input [7:0] got);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("MISMATCH %0s exp %h got %h", what, exp, got);
			end
		end
	endtask
	task rchk(input [8*8:1] what, input [5:0] a, input [7:0] exp);
		begin
			link.rd(a, rd_val);
			chk(what, exp, rd_val);
		end
	endtask
	// look for an interrupt pulse within n cycles
	task wait_int(input integer n, input exp);
		integer i;
		reg hit;
		begin
			hit = 1'b0;
			for (i = 0; i < n && !hit; i = i + 1) begin
				@(posedge clk);
				#1;
				hit = (alt_int === 1'b1);
			end
			chk("alt_int", {7'h00, exp}, {7'h00, hit});
		end
	endtask
	task pins(input [8*8:1] what, input exp, input got);
		chk(what, {7'h00, exp}, {7'h00, got});
	endtask
	task t_reset;
		begin
			rchk("ctrl", 6'h19, 8'h00);
			rchk("enable", 6'h1D, 8'h00);
			rchk("latch", 6'h21, 8'h00);
			pins("rx_line", 1'b1, link_data1_out);
		end
	endtask
	task t_regs;
		begin
			link.wr(6'h19, 8'hFF);
			rchk("ctrl", 6'h19, 8'h0E);
			link.wr(6'h1B, 8'h0A);
			rchk("ctrl", 6'h1A, 8'h04);
			pins("id_oe", 1'b0, id_oe);
			link.wr(6'h1A, 8'h03);
			rchk("ctrl", 6'h1B, 8'h06);
			pins("id_oe", 1'b1, id_oe);
			link.wr(6'h19, 8'h00);
			link.wr(6'h20, 8'hFF);
			link.wr(6'h3F, 8'hFF);
			rchk("status", 6'h20, 8'h00);
			rchk("unmapped", 6'h3F, 8'h00);
			link.wr(6'h1D, 8'hFF);
			rchk("enable", 6'h1F, 8'h23);
			link.wr(6'h1F, 8'h22);
			link.wr(6'h1E, 8'h02);
			rchk("enable", 6'h1E, 8'h03);
		end
	endtask
	task t_route;
		begin
			link.wr(6'h1A, 8'h0C);
			link_data0_in <= 1'b1;
			dp_pin <= 1'b0;
			repeat (8) @(posedge clk);
			pins("dm_out", 1'b1, dm_out);
			pins("rx_line", 1'b0, link_data1_out);
			link_data0_in <= 1'b0;
			dp_pin <= 1'b1;
			repeat (8) @(posedge clk);
			pins("dm_out", 1'b0, dm_out);
			pins("rx_line", 1'b1, link_data1_out);
			dp_pin <= 1'b0;
			link.wr(6'h1B, 8'h0C);
			repeat (8) @(posedge clk);
			pins("dm_oe", 1'b0, dm_oe);
			pins("rx_line", 1'b1, link_data1_out);
		end
	endtask
	task t_float;
		begin
			link.wr(6'h1D, 8'h02);
			id_float_pin <= 1'b1;
			wait_int(12, 1'b0);
			rchk("status", 6'h20, 8'h01);
			rchk("latch", 6'h21, 8'h00);
			link.wr(6'h1D, 8'h01);
			id_float_pin <= 1'b0;
			wait_int(12, 1'b0);
			link.wr(6'h1D, 8'h03);
			id_float_pin <= 1'b1;
			wait_int(12, 1'b1);
			link.wr(6'h1D, 8'h03);
			id_float_pin <= 1'b0;
			wait_int(12, 1'b1);
			rchk("latch", 6'h21, 8'h01);
			rchk("latch", 6'h21, 8'h00);
			link.wr(6'h1D, 8'h00);
			id_pullup_enable <= 1'b0;
			id_float_pin <= 1'b1;
			repeat (8) @(posedge clk);
			rchk("status", 6'h20, 8'h00);
			id_float_pin <= 1'b0;
			repeat (8) @(posedge clk);
			id_pullup_enable <= 1'b1;
		end
	endtask
	task t_rid;
		begin
			link.wr(6'h1D, 8'h20);
			link.wr(6'h36, 8'h10);
			wait_int(90, 1'b0);
			wait_int(30, 1'b1);
			rchk("status", 6'h20, 8'h68);
			rchk("status", 6'h20, 8'h68);
			rchk("latch", 6'h21, 8'h08);
			rchk("vendor", 6'h36, 8'h0D);
			rchk("status", 6'h20, 8'h28);
			link.wr(6'h1D, 8'h00);
			rid_adc_code <= 3'h7;
			link.wr(6'h37, 8'h50);
			rchk("vendor", 6'h36, 8'h55);
			pins("meas_en", 1'b1, rid_meas_enable);
			wait_int(130, 1'b1);
			rchk("vendor", 6'h37, 8'h4F);
			pins("meas_en", 1'b0, rid_meas_enable);
			rchk("latch", 6'h21, 8'h08);
		end
	endtask
	task stop_test;
		begin
			$display("checks %0d mismatches %0d", total_checks, n_fail);
			if (n_fail == 0 && total_checks > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	// free-running link clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// reset, scenarios, verdict
	initial begin
		reset = 1'b1;
		id_pullup_enable = 1'b1;
		id_float_pin = 1'b0;
		link_data0_in = 1'b0;
		dp_pin = 1'b1;
		rid_adc_code = 3'h5;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		t_reset;
		t_regs;
		t_route;
		t_float;
		t_rid;
		stop_test;
	end
	// cycle ceiling cuts a hang short
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 3000) begin
			n_fail = n_fail + 1;
			stop_test;
		end
	end
endmodule // ckr_carkit_regs_test
